/* logic/rfs_pkg.sv */
// Package for the regulator fault supervisor: constants, states, carriers
// How it works
// - Power-good low in shutdown and soft-start; high after good soft-start in window
// - Power-good low on UV, OV, OC on either output, or disable
// - After OV or OC latch-off power-good stays low until POR and soft-start
// - OV start: low-side on for all gates and ext phases, pg low, latch
// - Keep low-side on until differential output below 400mV; repeat on recurrence
// - After OV ends stay latched off until POR toggles
// - Supply below POR threshold during run re-arms pre-reset OV protection
// - Output below reference minus 300mV pulls power-good low only
// - Power-good returns after output rises above reference minus 250mV
// - Open sense line shuts down; auto soft-start when it clears
// - OC sequence when averaged current exceeds nominal level; both outputs alike
// - During soft-start OC level raised 1.4x to 140uA; restored after
// - Core OC: all gates low, ext phases tristate, pg low, wait 12ms
// - After OC wait, retry soft-start only if still enabled
// - Seven attempts total, then disable both regulators and latch off
// - Completed soft-start clears retry counter; nominal-only fault hiccups
// - NB OC disables only NB drivers; after 7 failures both latch off
// - Core channel over 140uA: high-side low, low-side high, no shutdown
// - High-side blocked until that channel current falls below the limit
// - Soft-start completes when reference ramp reaches final target
package rfs_pkg;
  // ----------------------------------------------------------------
  // Counts and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OC_WAIT_MS = 12;
  localparam int unsigned OC_WAIT_CYC = OC_WAIT_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] RETRY_MAX = 3'h7;
  localparam int unsigned NUM_CH = 4;
  localparam logic [2:0] RETRY_RST = 3'h0;

  // ----------------------------------------------------------------
  // Regulator sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SOFT = 3'b001,
    ST_RUN = 3'b010,
    ST_OCWAIT = 3'b011,
    ST_LATCH = 3'b100
  } rfs_state_t;

  // Analog comparator results for one output
  typedef struct packed {
    logic under_trip;     // Below reference minus 300mV
    logic under_recover;  // Above reference minus 250mV
    logic over_trip;      // overvoltage_trip comparator
    logic diff_low;       // differential_output_voltage below 400mV
    logic oc_nominal;     // Average current above 100uA
    logic oc_boosted;     // Average current above 140uA
  } rfs_sense_t;

  // Gate commands for one switching channel
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } rfs_gate_t;
endpackage

/* logic/rfs_supervisor.sv */
// Fault supervisor and protection sequencer for the dual regulator
`timescale 1ns/1ps
module rfs_supervisor #(
  parameter int unsigned OC_WAIT = rfs_pkg::OC_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic enable_in,
  input wire logic por_ok,
  input wire logic nb_active,
  input wire logic [1:0] ext_phase_active,
  input wire rfs_pkg::rfs_sense_t core_sense,
  input wire rfs_pkg::rfs_sense_t nb_sense,
  input wire logic sense_open,
  input wire logic ramp_done,
  input wire logic [rfs_pkg::NUM_CH-1:0] channel_current_limit,
  input wire rfs_pkg::rfs_gate_t [rfs_pkg::NUM_CH-1:0] core_pwm_in,
  input wire rfs_pkg::rfs_gate_t nb_pwm_in,
  output logic power_good_out,
  output logic power_good_oe,
  output rfs_pkg::rfs_gate_t [1:0] core_gate,
  output rfs_pkg::rfs_gate_t nb_gate,
  output logic [1:0] ext_phase_drive,
  output logic [1:0] ext_phase_oe,
  output logic soft_start_run,
  output logic oc_level_boost,
  output logic pre_por_ovp_on
);
  import rfs_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    rfs_state_t st;
    logic [31:0] wait_cnt;
    logic [2:0] retries;
    logic ov_latched;
    logic ov_clamp;
    logic oc_nb_only;
    logic uv_low;
    logic [NUM_CH-1:0] hs_block;
    logic pg;
    rfs_gate_t [1:0] cg;
    rfs_gate_t ng;
    logic [1:0] ep;
    logic [1:0] epoe;
    logic ss;
    logic boost;
    logic prepor;
  } rfs_reg_t;

  rfs_reg_t r_q;
  rfs_reg_t r_d;

  // Gate pair held by a cycle limit or passed from modulator
  function automatic rfs_gate_t limit_gate(input rfs_gate_t g,
                                           input logic blk);
    rfs_gate_t o;
    o = g;
    if (blk) begin
      o.high_side_gate = 1'b0;
      o.low_side_gate = 1'b1;
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic ov_any;
  logic oc_core;
  logic oc_nb;
  logic uv_any;
  logic uv_clear;
  logic ok_to_run;
  rfs_gate_t [1:0] ext_lim;

  always_comb begin
    // External phases carry only the high-side command, limit applied first
    for (int i = 0; i < 2; i++) begin
      ext_lim[i] = limit_gate(core_pwm_in[i+2],
                              channel_current_limit[i+2]);
    end
    ov_any = core_sense.over_trip | (nb_active & nb_sense.over_trip);
    // Boosted level in soft-start only
    oc_core = (r_q.st == ST_SOFT) ? core_sense.oc_boosted
                                  : core_sense.oc_nominal;
    oc_nb = nb_active & ((r_q.st == ST_SOFT) ? nb_sense.oc_boosted
                                             : nb_sense.oc_nominal);
    uv_any = core_sense.under_trip | (nb_active & nb_sense.under_trip);
    uv_clear = core_sense.under_recover &
               (~nb_active | nb_sense.under_recover);
    ok_to_run = enable_in & por_ok & ~sense_open;
    r_d = r_q;
    r_d.prepor = ~por_ok;

    // Cycle limit: block high side until the channel current falls
    r_d.hs_block = channel_current_limit;

    // Undervoltage only flags power-good, hysteresis 300/250mV
    if (uv_any) begin
      r_d.uv_low = 1'b1;
    end else if (uv_clear) begin
      r_d.uv_low = 1'b0;
    end

    unique case (r_q.st)
      ST_OFF: begin
        if (ok_to_run) begin
          r_d.st = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (!ok_to_run) begin
          r_d.st = ST_OFF;
        end else if (oc_core || oc_nb) begin
          r_d.st = ST_OCWAIT;
          r_d.oc_nb_only = oc_nb & ~oc_core;
          r_d.wait_cnt = 32'h0000_0000;
          r_d.retries = r_q.retries + 3'h1;
        end else if (r_q.st == ST_SOFT && ramp_done) begin
          r_d.st = ST_RUN;
          r_d.retries = RETRY_RST;
        end
      end
      ST_OCWAIT: begin
        r_d.wait_cnt = r_q.wait_cnt + 32'h0000_0001;
        if (r_q.wait_cnt >= OC_WAIT - 1) begin
          if (r_q.retries >= RETRY_MAX) begin
            r_d.st = ST_LATCH;
          end else if (ok_to_run) begin
            r_d.st = ST_SOFT;
          end else begin
            r_d.st = ST_OFF;
          end
        end
      end
      ST_LATCH: begin
      end
      default: r_d.st = ST_LATCH;
    endcase

    // Overvoltage latches off; only reset (POR) clears it
    if (ov_any && r_q.st != ST_OFF) begin
      r_d.ov_latched = 1'b1;
    end
    if (ov_any) begin
      r_d.ov_clamp = r_q.ov_latched | (r_q.st != ST_OFF);
    end else if (core_sense.diff_low) begin
      r_d.ov_clamp = 1'b0;
    end
    if (r_d.ov_latched) begin
      r_d.st = ST_LATCH;
    end

    // Soft-start status and OC level boost
    r_d.ss = (r_d.st == ST_SOFT);
    r_d.boost = (r_d.st == ST_SOFT);

    // Power-good: only in run, no UV, no faults
    r_d.pg = (r_d.st == ST_RUN) & ~r_d.uv_low & ~uv_any & ~ov_any &
             ~oc_core & ~oc_nb & ok_to_run;

    // Gate outputs by state
    r_d.epoe = 2'b00;
    r_d.ep = 2'b00;
    for (int i = 0; i < 2; i++) begin
      r_d.cg[i] = '0;
    end
    r_d.ng = '0;
    if (r_d.ov_clamp) begin
      // Crowbar: every low side on, ext phases driven low
      for (int i = 0; i < 2; i++) begin
        r_d.cg[i] = 2'b01;
      end
      r_d.ng = 2'b01;
      r_d.epoe = ext_phase_active;
    end else if (r_d.st == ST_SOFT || r_d.st == ST_RUN) begin
      for (int i = 0; i < 2; i++) begin
        r_d.cg[i] = limit_gate(core_pwm_in[i], r_d.hs_block[i]);
      end
      for (int i = 0; i < 2; i++) begin
        r_d.ep[i] = ext_lim[i].high_side_gate;
      end
      r_d.epoe = ext_phase_active;
      r_d.ng = nb_active ? nb_pwm_in : 2'b00;
    end else if (r_d.st == ST_OCWAIT && r_d.oc_nb_only) begin
      // NB trip: core keeps switching
      for (int i = 0; i < 2; i++) begin
        r_d.cg[i] = limit_gate(core_pwm_in[i], r_d.hs_block[i]);
        r_d.ep[i] = ext_lim[i].high_side_gate;
      end
      r_d.epoe = ext_phase_active;
    end
    // Core OC wait and latch: all gates low, ext tristate (defaults)
  end

  // ----------------------------------------------------------------
  // State register; reset is the power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_q <= '0;
      r_q.prepor <= 1'b1;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops; open drain pulls low when pg clear
  // ----------------------------------------------------------------
  assign power_good_out = 1'b0;
  assign power_good_oe = ~r_q.pg;
  assign core_gate = r_q.cg;
  assign nb_gate = r_q.ng;
  assign ext_phase_drive = r_q.ep;
  assign ext_phase_oe = r_q.epoe;
  assign soft_start_run = r_q.ss;
  assign oc_level_boost = r_q.boost;
  assign pre_por_ovp_on = r_q.prepor;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pg_off_soft_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.st == ST_SOFT |-> power_good_oe)
    else $error("power good released during soft-start");
  pg_ov_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && core_sense.over_trip && r_q.st == ST_RUN |=> power_good_oe)
    else $error("power good high after overvoltage");
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.st == ST_LATCH |=> r_q.st == ST_LATCH && power_good_oe)
    else $error("latched off state left");
  ov_clamp_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.ov_clamp |-> core_gate[0] == 2'b01 && core_gate[1] == 2'b01)
    else $error("crowbar gates wrong");
  oc_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.st == ST_OCWAIT && !r_q.oc_nb_only |->
    core_gate == '0 && ext_phase_oe == 2'b00)
    else $error("core trip gates not off");
  retry_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && r_q.st == ST_SOFT && r_d.st == ST_RUN |=>
    r_q.retries == 3'h0)
    else $error("retry counter not cleared");
  boost_ss_a: assert property (@(posedge sys_clk) disable iff (reset)
    oc_level_boost == soft_start_run)
    else $error("oc boost not tied to soft-start");
  retry_cap_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.st == ST_SOFT |-> r_q.retries < RETRY_MAX)
    else $error("retry beyond seven attempts");
  hs_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    r_q.hs_block[0] && !r_q.ov_clamp && r_q.st == ST_RUN |->
    core_gate[0] == 2'b01)
    else $error("channel limit not applied");
endmodule

/* test/rfs_stage_model.sv */
// Power stage model: wire level of the external phase drive lines
`timescale 1ns/1ps
module rfs_stage_model (
  input wire logic sys_clk,
  input wire logic [1:0] ext_phase_drive,
  input wire logic [1:0] ext_phase_oe,
  output logic [1:0] ext_wire
);
  import rfs_pkg::*;
  logic [1:0] last_q;
  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  // Released lines toggle so a stale level is never mistaken for drive
  initial last_q = 2'h0;
  always @(posedge sys_clk) begin
    last_q <= ext_wire;
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ext_wire[i] = ext_phase_oe[i] ? ext_phase_drive[i] : ~last_q[i];
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/1ps
module tb_top;
  import rfs_pkg::*;
  localparam int OCW = 20;
  logic sys_clk = 0, reset = 1, en = 1, por = 1, so = 0, rd = 0;
  rfs_sense_t cs = 6'h14, ns = 6'h14;
  logic [3:0] ccl = 4'h0;
  rfs_gate_t [3:0] cpw = 8'haa;
  logic pg, pg_oe, ssr, boost, prep;
  rfs_gate_t [1:0] cg;
  rfs_gate_t ng;
  logic [1:0] epd, epo, ew;
  int fails = 0, num_checks = 0, n;
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  rfs_supervisor #(.OC_WAIT(OCW)) dut (.sys_clk(sys_clk), .reset(reset),
    .clk_en(1'b1), .enable_in(en), .por_ok(por), .nb_active(1'b1),
    .ext_phase_active(2'h3), .core_sense(cs), .nb_sense(ns),
    .sense_open(so), .ramp_done(rd), .channel_current_limit(ccl),
    .core_pwm_in(cpw), .nb_pwm_in(2'h2), .power_good_out(pg),
    .power_good_oe(pg_oe), .core_gate(cg), .nb_gate(ng),
    .ext_phase_drive(epd), .ext_phase_oe(epo), .soft_start_run(ssr),
    .oc_level_boost(boost), .pre_por_ovp_on(prep));
  rfs_stage_model stage (.sys_clk(sys_clk), .ext_phase_drive(epd),
    .ext_phase_oe(epo), .ext_wire(ew));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait k edges, then let their updates land
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic up();
    @(posedge sys_clk) reset <= 1;
    rd <= 0;
    cs <= 6'h14;
    ns <= 6'h14;
    en <= 1;
    por <= 1;
    repeat (5) @(posedge sys_clk);
    reset <= 0;
    tick(4);
    chk(ssr, 1);
    chk(boost, 1);
    chk(pg_oe, 1);
    @(posedge sys_clk) rd <= 1;
    tick(4);
    chk(ssr, 0);
    chk(boost, 0);
    chk(pg_oe, 0);
  endtask
  task automatic wait_ssr();
    n = 0;
    while (ssr !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_uv_ocl();
    up();
    @(posedge sys_clk) ns <= 6'h20;
    tick(3);
    chk(pg_oe, 1);
    chk(cg, 4'ha);
    @(posedge sys_clk) ns <= 6'h00;
    tick(3);
    chk(pg_oe, 1);
    @(posedge sys_clk) ns <= 6'h14;
    tick(3);
    chk(pg_oe, 0);
    @(posedge sys_clk) ccl <= 4'h1;
    tick(2);
    chk(cg[0], 2'h1);
    chk(pg_oe, 0);
    @(posedge sys_clk) ccl <= 4'h0;
    tick(2);
    chk(cg[0], 2'h2);
    chk(ng, 2'h2);
    chk(ew, 2'h3);
    @(posedge sys_clk) ns <= 6'h16;
    tick(2);
    chk(cg, 4'ha);
    chk(ng, 2'h0);
    chk(pg_oe, 1);
    @(posedge sys_clk) ns <= 6'h14;
    $display("test uv and channel limit done");
  endtask
  task automatic t_oc();
    up();
    @(posedge sys_clk) cs <= 6'h16;
    tick(2);
    chk({cg, epo, pg_oe}, 7'h01);
    chk(ng, 2'h0);
    @(posedge sys_clk) cs <= 6'h14;
    wait_ssr();
    chk(n >= OCW - 4 && n <= OCW + 2, 1);
    tick(4);
    @(posedge sys_clk) cs <= 6'h16;
    repeat (2) @(posedge sys_clk);
    en <= 0;
    tick(OCW + 8);
    chk(ssr, 0);
    @(posedge sys_clk) en <= 1;
    cs <= 6'h17;
    tick(9 * (OCW + 8));
    @(posedge sys_clk) cs <= 6'h14;
    tick(2 * OCW);
    chk(ssr, 0);
    chk(pg_oe, 1);
    $display("test overcurrent done");
  endtask
  task automatic t_ov();
    up();
    @(posedge sys_clk) cs <= 6'h18;
    tick(2);
    chk(cg, 4'h5);
    chk(pg_oe, 1);
    chk(ng, 2'h1);
    chk(ew, 2'h0);
    @(posedge sys_clk) cs <= 6'h10;
    tick(3);
    chk(cg, 4'h5);
    @(posedge sys_clk) cs <= 6'h18;
    tick(3);
    chk(cg, 4'h5);
    @(posedge sys_clk) cs <= 6'h14;
    tick(OCW);
    chk(cg, 4'h0);
    chk(ssr, 0);
    chk(pg_oe, 1);
    $display("test overvoltage done");
  endtask
  task automatic t_open_por();
    up();
    @(posedge sys_clk) so <= 1;
    tick(3);
    chk(pg_oe, 1);
    @(posedge sys_clk) so <= 0;
    rd <= 0;
    wait_ssr();
    chk(ssr, 1);
    @(posedge sys_clk) por <= 0;
    tick(3);
    chk(prep, 1);
    chk(pg_oe, 1);
    chk(pg, 0);
    $display("test open sense and supply loss done");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    t_uv_ocl();
    t_oc();
    t_ov();
    t_open_por();
    print_verdict();
  end
  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule
